// >>> include/sdp_pkg.sv
// Shared constants and carrier types for the synchronous dual-port RAM
package sdp_pkg;

    // ************************************************************
    // Array geometry
    // ************************************************************
    localparam int SDP_PORTS   = 2;
    localparam int SDP_ADDR_W  = 16;
    localparam int SDP_DEPTH   = 65536;
    localparam int SDP_DATA_W  = 18;
    localparam int SDP_BYTE_W  = 9;
    localparam int SDP_LANES   = 2;

    // ************************************************************
    // Reset values and synchroniser depth
    // ************************************************************
    localparam logic [15:0] SDP_ADDR_RST = 16'h0000;
    localparam logic [17:0] SDP_DATA_RST = 18'h0_0000;
    localparam logic [1:0]  SDP_LANE_OFF = 2'h0;
    localparam int          SDP_SYNC_STAGES = 3;

    // ************************************************************
    // Synchronous pin group of one port
    // ************************************************************
    typedef struct packed {
        logic        chip_sel_low_active;
        logic        chip_sel_high_active;
        logic        rd_wr_n;
        logic        addr_strobe_n;
        logic        addr_counter_advance_n;
        logic        addr_counter_clear_n;
        logic        upper_byte_sel_n;
        logic        lower_byte_sel_n;
        logic [15:0] addr;
        logic [17:0] wdata;
    } sdp_port_in_t;

    // ************************************************************
    // Output group of one port
    // ************************************************************
    typedef struct packed {
        logic [17:0] rdata;
        logic [1:0]  lane_oe;
        logic        standby;
    } sdp_port_out_t;

endpackage

// >>> src/sdp_addr_unit.sv
// Address strobe, counter and counter clear logic of one port
`timescale 1ns/1ps
module sdp_addr_unit #(
    parameter int ADDR_W = sdp_pkg::SDP_ADDR_W
) (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rstn_i,
    // Address controls, same clock domain
    input  wire logic              addr_strobe_n_i,
    input  wire logic              addr_counter_advance_n_i,
    input  wire logic              addr_counter_clear_n_i,
    input  wire logic [ADDR_W-1:0] ext_addr_i,
    // Internal access address
    output logic      [ADDR_W-1:0] int_addr_o
);

    // ************************************************************
    // Address selection
    // ************************************************************
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic [ADDR_W-1:0] addr_inc;
    logic              load_ext;
    logic              clear_cnt;
    logic              advance_cnt;

    assign load_ext    = ~addr_strobe_n_i;
    assign clear_cnt   = addr_strobe_n_i & ~addr_counter_clear_n_i;
    assign advance_cnt = addr_strobe_n_i & addr_counter_clear_n_i
                         & ~addr_counter_advance_n_i;
    assign addr_inc    = addr_ff + ADDR_W'(1);

    // Strobe low picks the pins, otherwise the counter
    assign nxt_addr = load_ext    ? ext_addr_i :
                      clear_cnt   ? ADDR_W'(sdp_pkg::SDP_ADDR_RST) :
                      advance_cnt ? addr_inc :
                                    addr_ff;

    // ************************************************************
    // Address register
    // ************************************************************
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            addr_ff <= ADDR_W'(sdp_pkg::SDP_ADDR_RST);
        end
        else
        begin
            addr_ff <= nxt_addr;
        end
    end

    assign int_addr_o = addr_ff;

endmodule

// >>> src/sdp_ram.sv
// Synchronous dual-port RAM core with per-port control and output timing
`timescale 1ns/1ps
module sdp_ram #(
    parameter int PORTS  = sdp_pkg::SDP_PORTS,
    parameter int ADDR_W = sdp_pkg::SDP_ADDR_W,
    parameter int DEPTH  = sdp_pkg::SDP_DEPTH,
    parameter int DATA_W = sdp_pkg::SDP_DATA_W,
    parameter int BYTE_W = sdp_pkg::SDP_BYTE_W
) (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rstn_i,
    // Synchronous pins of each port
    input  wire sdp_pkg::sdp_port_in_t port_i [PORTS],
    // Asynchronous pins of each port
    input  wire logic                  out_en_n_i [PORTS],
    input  wire logic                  output_timing_sel_i [PORTS],
    // Data out, lane enables and standby of each port
    output sdp_pkg::sdp_port_out_t     port_o [PORTS]
);

    // ************************************************************
    // Storage array
    // ************************************************************
    logic [DATA_W-1:0] mem [DEPTH];

    // ************************************************************
    // Per-port state shared with the write process
    // ************************************************************
    logic [ADDR_W-1:0] int_addr   [PORTS];
    logic              wr_en_ff   [PORTS];
    logic [1:0]        wr_lane_ff [PORTS];
    logic [DATA_W-1:0] wdata_ff   [PORTS];

    genvar gp;
    generate
        for (gp = 0; gp < PORTS; gp++)
        begin : g_port

            // ****************************************************
            // Address path
            // ****************************************************
            sdp_addr_unit #(
                .ADDR_W (ADDR_W)
            ) u_addr (
                .clock_i                  (clock_i),
                .rstn_i                   (rstn_i),
                .addr_strobe_n_i          (port_i[gp].addr_strobe_n),
                .addr_counter_advance_n_i (port_i[gp].addr_counter_advance_n),
                .addr_counter_clear_n_i   (port_i[gp].addr_counter_clear_n),
                .ext_addr_i               (port_i[gp].addr),
                .int_addr_o               (int_addr[gp])
            );

            // ****************************************************
            // Timing select synchroniser
            // ****************************************************
            logic [2:0] tsel_sync_ff;
            logic       pipe_mode_ff;
            logic       tsel_agree;

            assign tsel_agree = (tsel_sync_ff[1] == tsel_sync_ff[2]);

            always_ff @(posedge clock_i)
            begin
                if (!rstn_i)
                begin
                    tsel_sync_ff <= 3'h0;
                    pipe_mode_ff <= 1'b0;
                end
                else
                begin
                    tsel_sync_ff <= {tsel_sync_ff[1:0], output_timing_sel_i[gp]};
                    if (tsel_agree)
                    begin
                        pipe_mode_ff <= tsel_sync_ff[2];
                    end
                end
            end

            // ****************************************************
            // Input control decode
            // ****************************************************
            logic       sel_now;
            logic [1:0] lane_now;

            assign sel_now  = ~port_i[gp].chip_sel_low_active
                              & port_i[gp].chip_sel_high_active;
            assign lane_now = {~port_i[gp].upper_byte_sel_n,
                               ~port_i[gp].lower_byte_sel_n};

            // ****************************************************
            // Input registers
            // ****************************************************
            logic       sel_ff;
            logic       sel_prev_ff;
            logic       rd_ff;
            logic [1:0] lane_ff;

            always_ff @(posedge clock_i)
            begin
                if (!rstn_i)
                begin
                    sel_ff          <= 1'b0;
                    sel_prev_ff     <= 1'b0;
                    rd_ff           <= 1'b0;
                    lane_ff         <= sdp_pkg::SDP_LANE_OFF;
                    wr_en_ff[gp]    <= 1'b0;
                    wr_lane_ff[gp]  <= sdp_pkg::SDP_LANE_OFF;
                    wdata_ff[gp]    <= sdp_pkg::SDP_DATA_RST;
                end
                else
                begin
                    sel_ff          <= sel_now;
                    sel_prev_ff     <= sel_ff;
                    rd_ff           <= port_i[gp].rd_wr_n;
                    lane_ff         <= lane_now;
                    wr_en_ff[gp]    <= sel_now & ~port_i[gp].rd_wr_n;
                    wr_lane_ff[gp]  <= lane_now;
                    wdata_ff[gp]    <= port_i[gp].wdata;
                end
            end

            // ****************************************************
            // Read path
            // ****************************************************
            logic [DATA_W-1:0] flow_data_ff;
            logic [DATA_W-1:0] pipe_data_ff;
            logic [1:0]        flow_drv_ff;
            logic [1:0]        pipe_drv_ff;
            logic              do_read;
            logic              pipe_arm_ff;
            logic [1:0]        nxt_flow_drv;
            logic [1:0]        nxt_pipe_drv;

            // Standby ports skip the array read
            assign do_read      = sel_ff & rd_ff;
            assign nxt_flow_drv = lane_ff & {2{do_read}};
            // Pipelined drive needs this and the previous cycle selected
            assign nxt_pipe_drv = flow_drv_ff & {2{pipe_arm_ff}};

            always_ff @(posedge clock_i)
            begin
                if (!rstn_i)
                begin
                    flow_data_ff <= sdp_pkg::SDP_DATA_RST;
                    pipe_data_ff <= sdp_pkg::SDP_DATA_RST;
                    flow_drv_ff  <= sdp_pkg::SDP_LANE_OFF;
                    pipe_drv_ff  <= sdp_pkg::SDP_LANE_OFF;
                    pipe_arm_ff  <= 1'b0;
                end
                else
                begin
                    if (do_read)
                    begin
                        flow_data_ff <= mem[int_addr[gp]];
                    end
                    pipe_data_ff <= flow_data_ff;
                    flow_drv_ff  <= nxt_flow_drv;
                    pipe_drv_ff  <= nxt_pipe_drv;
                    pipe_arm_ff  <= sel_ff & sel_prev_ff;
                end
            end

            // ****************************************************
            // Output selection
            // ****************************************************
            logic [1:0] lane_drv;

            assign lane_drv = pipe_mode_ff ? pipe_drv_ff : flow_drv_ff;

            assign port_o[gp].rdata   = pipe_mode_ff ? pipe_data_ff : flow_data_ff;
            assign port_o[gp].lane_oe = lane_drv & {2{~out_en_n_i[gp]}};
            assign port_o[gp].standby = ~sel_ff;
        end
    endgenerate

    // ************************************************************
    // Write commit, lane masked
    // ************************************************************
    always_ff @(posedge clock_i)
    begin
        for (int p = 0; p < PORTS; p++)
        begin
            // Later port wins a same-address collision
            if (wr_en_ff[p] && wr_lane_ff[p][0])
            begin
                mem[int_addr[p]][BYTE_W-1:0] <= wdata_ff[p][BYTE_W-1:0];
            end
            if (wr_en_ff[p] && wr_lane_ff[p][1])
            begin
                mem[int_addr[p]][DATA_W-1:BYTE_W] <= wdata_ff[p][DATA_W-1:BYTE_W];
            end
        end
    end

endmodule

// >>> testbench/sdp_ram_properties.sv
// Concurrent checks on the pins of port 0 of the dual-port RAM
`timescale 1ns/1ps
module sdp_ram_properties #(
    parameter int PORTS = sdp_pkg::SDP_PORTS
) (
    // Clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   rstn_i,
    // Watched pins
    input  wire sdp_pkg::sdp_port_in_t  port_i [PORTS],
    input  wire logic                   out_en_n_i [PORTS],
    input  wire logic                   output_timing_sel_i [PORTS],
    input  wire sdp_pkg::sdp_port_out_t port_o [PORTS]
);
    wire sel0 = !port_i[0].chip_sel_low_active && port_i[0].chip_sel_high_active;
    wire rd0  = sel0 && port_i[0].rd_wr_n && !port_i[0].upper_byte_sel_n
                && !port_i[0].lower_byte_sel_n;
    wire flow = !output_timing_sel_i[0];
    wire pipe = output_timing_sel_i[0];
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    a_reset_quiet: assert property (disable iff (1'b0)
        !rstn_i |=> port_o[0].lane_oe == 2'b00 && port_o[0].standby)
        else $error("outputs not quiet after reset");
    a_oe_async: assert property (out_en_n_i[0] |-> port_o[0].lane_oe == 2'b00)
        else $error("lanes driven with output enable off");
    a_flow_float: assert property (flow [*5] ##0 !sel0
        |=> ##1 port_o[0].lane_oe == 2'b00)
        else $error("lanes driven after deselect");
    a_flow_lanes: assert property (flow [*5] ##0 rd0
        |=> ##1 (out_en_n_i[0] || port_o[0].lane_oe == 2'b11))
        else $error("lanes not driven after read");
    a_upper_float: assert property (flow [*5] ##0 port_i[0].upper_byte_sel_n
        |=> ##1 !port_o[0].lane_oe[1])
        else $error("upper lane driven while not selected");
    a_desel_standby: assert property (!sel0 |=> port_o[0].standby)
        else $error("no standby after deselect");
    a_pipe_wait: assert property (pipe [*5] ##0 !sel0
        |=> ##2 (port_o[0].lane_oe == 2'b00) ##1 (port_o[0].lane_oe == 2'b00))
        else $error("pipelined lanes driven too soon after deselect");
    a_pipe_late: assert property (pipe [*5] ##0 sel0 ##1 rd0
        |=> ##2 (out_en_n_i[0] || port_o[0].lane_oe == 2'b11))
        else $error("pipelined lanes not driven after read");
    c_flow_read: cover property (flow [*5] ##0 rd0 ##1 !out_en_n_i[0]);
    c_pipe_read: cover property (pipe [*5] ##0 sel0 ##1 rd0);
    c_pipe_reselect: cover property (pipe [*5] ##0 !sel0 ##1 sel0 ##1 !sel0);
    c_clear: cover property (sel0 && port_i[0].addr_strobe_n && !port_i[0].addr_counter_clear_n);
endmodule

bind sdp_ram sdp_ram_properties #(.PORTS(PORTS)) u_props (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .port_i(port_i),
    .out_en_n_i(out_en_n_i),
    .output_timing_sel_i(output_timing_sel_i),
    .port_o(port_o)
);

// >>> testbench/sdp_host.sv
// Host-side view of the data bus of one port
`timescale 1ns/1ps
module sdp_host (
    // Clock
    input  wire logic                   clock_i,
    // Pins from the port
    input  wire sdp_pkg::sdp_port_out_t pins_i,
    // Bus level seen by the host
    output logic [17:0]                 bus_o
);
    logic [17:0] last_ff;
    // Undriven lanes show the inverse of the last level
    assign bus_o[17:9] = pins_i.lane_oe[1] ? pins_i.rdata[17:9] : ~last_ff[17:9];
    assign bus_o[8:0]  = pins_i.lane_oe[0] ? pins_i.rdata[8:0] : ~last_ff[8:0];
    always_ff @(posedge clock_i)
    begin
        last_ff <= bus_o;
    end
endmodule

// >>> testbench/tb.sv
// Self-checking testbench of the dual-port RAM
`timescale 1ns/1ps
module tb;
    logic                   clock_i;
    logic                   rstn_i;
    sdp_pkg::sdp_port_in_t  port_i [2];
    logic                   out_en_n_i [2];
    logic                   output_timing_sel_i [2];
    sdp_pkg::sdp_port_out_t port_o [2];
    wire [17:0]             bus [2];
    logic [17:0]            mem [logic [15:0]];
    logic [18:0]            op;
    logic [15:0]            a;
    logic [15:0]            cur;
    logic [15:0]            prev;
    int                     errors;
    int                     n_tests;
    localparam logic [18:0] CTR_OPS [5] = '{{3'b011, 16'h0002}, {3'b101, 16'h0000},
        {3'b111, 16'h0000}, {3'b110, 16'h0000}, {3'b100, 16'h0000}};
    sdp_ram dut (.clock_i(clock_i), .rstn_i(rstn_i), .port_i(port_i), .out_en_n_i(out_en_n_i),
        .output_timing_sel_i(output_timing_sel_i), .port_o(port_o));
    for (genvar p = 0; p < 2; p++)
    begin : g_host
        sdp_host u_host (.clock_i(clock_i), .pins_i(port_o[p]), .bus_o(bus[p]));
    end
    function automatic logic [15:0] nxt_addr(logic [15:0] c, logic [18:0] o);
        if (!o[18]) return o[15:0];
        if (!o[16]) return 16'h0000;
        if (!o[17]) return c + 16'h0001;
        return c;
    endfunction
    function automatic logic [17:0] merge(logic [17:0] old, logic [17:0] wd, logic [1:0] bs_n);
        return {bs_n[1] ? old[17:9] : wd[17:9], bs_n[0] ? old[8:0] : wd[8:0]};
    endfunction
    task automatic test_done();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_word(logic [17:0] exp, logic [17:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic chk_flags(logic [1:0] exp, logic [1:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic step();
        @(negedge clock_i);
    endtask
    task automatic acc(int p, logic rw, logic [15:0] ad, logic [17:0] wd, logic [1:0] bs_n,
        logic [2:0] ctl);
        port_i[p] = '{1'b0, 1'b1, rw, ctl[2], ctl[1], ctl[0], bs_n[1], bs_n[0], ad, wd};
    endtask
    task automatic wr(int p, logic [15:0] ad, logic [17:0] wd, logic [1:0] bs_n);
        acc(p, 1'b0, ad, wd, bs_n, 3'b011);
        mem[ad] = merge(mem.exists(ad) ? mem[ad] : wd, wd, bs_n);
        step();
    endtask
    task automatic rd(logic [15:0] ad, logic [1:0] bs_n, bit pipe);
        logic [17:0] m;
        m = {{9{~bs_n[1]}}, {9{~bs_n[0]}}};
        for (int p = 0; p < 2; p++) acc(p, 1'b1, ad, 18'h0_0000, bs_n, 3'b011);
        step();
        chk_flags(2'b00, {port_o[1].standby, port_o[0].standby});
        if (pipe) step();
        for (int p = 0; p < 2; p++) port_i[p].chip_sel_high_active = 1'b0;
        step();
        chk_flags(2'b11, {port_o[1].standby, port_o[0].standby});
        if (pipe) step();
        for (int p = 0; p < 2; p++)
        begin
            chk_flags(~bs_n, port_o[p].lane_oe);
            chk_word(mem[ad] & m, bus[p] & m);
        end
    endtask
    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    initial
    begin
        #(1000 * 100);
        errors++;
        test_done();
    end
    initial
    begin
        rstn_i = 1'b0;
        errors = 0;
        n_tests = 0;
        for (int p = 0; p < 2; p++) port_i[p] = '0;
        out_en_n_i = '{1'b0, 1'b0};
        output_timing_sel_i = '{1'b0, 1'b0};
        void'($urandom(71392));
        repeat (20) step();
        chk_flags(2'b11, {port_o[1].standby, port_o[0].standby});
        chk_word(18'h0_0000, port_o[0].rdata);
        chk_word(18'h0_0000, port_o[1].rdata);
        rstn_i = 1'b1;
        for (int i = 0; i < 16; i++) wr(i % 2, 16'(i), 18'($urandom), 2'b00);
        for (int i = 0; i < 8; i++)
        begin
            a = 16'($urandom);
            wr(0, a, 18'($urandom), 2'b00);
            rd(a, 2'b00, 1'b0);
        end
        // Deselected write leaves the location as a no-operation cycle
        port_i[0] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0020, 18'($urandom)};
        step();
        wr(0, 16'h0020, 18'($urandom), 2'b00);
        wr(0, 16'h0020, 18'($urandom), 2'b10);
        rd(16'h0020, 2'b00, 1'b0);
        rd(16'h0020, 2'b01, 1'b0);
        for (int p = 0; p < 2; p++) acc(p, 1'b1, 16'h0020, 18'h0_0000, 2'b00, 3'b011);
        step();
        step();
        out_en_n_i[0] = 1'b1;
        #1 chk_flags(2'b00, port_o[0].lane_oe);
        out_en_n_i[0] = 1'b0;
        #1 chk_flags(2'b11, port_o[0].lane_oe);
        cur = 16'h0000;
        for (int i = 0; i < 13; i++)
        begin
            op = (i < 5) ? CTR_OPS[i] : {3'($urandom), 16'($urandom_range(3))};
            acc(0, 1'b1, op[15:0], 18'h0_0000, 2'b00, op[18:16]);
            cur = nxt_addr(cur, op);
            step();
            if (i > 0) chk_word(mem[prev], bus[0]);
            prev = cur;
        end
        port_i[0].chip_sel_high_active = 1'b0;
        step();
        chk_word(mem[prev], bus[0]);
        output_timing_sel_i = '{1'b1, 1'b1};
        repeat (5) step();
        for (int i = 0; i < 8; i++) rd(16'($urandom_range(15)), 2'b00, 1'b1);
        for (int p = 0; p < 2; p++) acc(p, 1'b1, 16'h0003, 18'h0_0000, 2'b00, 3'b011);
        step();
        for (int p = 0; p < 2; p++) port_i[p].chip_sel_high_active = 1'b0;
        step();
        chk_flags(2'b00, port_o[1].lane_oe);
        step();
        chk_flags(2'b00, port_o[1].lane_oe);
        test_done();
    end
endmodule
